// *** zcsm_host_model.sv ***
// partner model: slow motor whose position feedback follows the drive command
`timescale 1ns/1ps
module zcsm_host_model #(
    parameter int POS_W = 32
) (
    input  wire logic                    clk_i,
    input  wire logic                    rst_n_i,
    input  wire logic signed [15:0]      speed_cmd_i,
    input  wire logic signed [POS_W-1:0] kick_i,
    output logic signed [POS_W-1:0]      motor_pos_o
);
    logic [2:0] div_q;

    // host only reads feedback and never closes a position loop of its own
    // one pulse per eight cycles keeps the clamp loop calm at the default gain
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            div_q       <= 3'h0;
            motor_pos_o <= POS_W'(4096);
        end else begin
            div_q <= div_q + 3'h1;
            if (div_q == 3'h7 && speed_cmd_i != 16'sh0000) begin
                motor_pos_o <= motor_pos_o + kick_i + POS_W'(speed_cmd_i < 0 ? -1 : 1);
            end else begin
                motor_pos_o <= motor_pos_o + kick_i;
            end
        end
    end
endmodule

// *** zcsm_monitor.sv ***
// checker: port-level assertions for the zero clamp / speed match block
`timescale 1ns/1ps
module zcsm_monitor #(
    parameter int N_OUTPUTS = 3,
    parameter int POS_W     = 32
) (
    input wire logic                    clk_i,
    input wire logic                    rst_n_i,
    input wire logic [7:0]              avs_address_i,
    input wire logic                    avs_read_i,
    input wire logic                    avs_write_i,
    input wire logic                    avs_waitrequest_o,
    input wire logic [1:0]              avs_response_o,
    input wire logic                    speed_ctrl_active_i,
    input wire logic signed [15:0]      speed_ref_i,
    input wire logic signed [POS_W-1:0] motor_pos_i,
    input wire logic signed [15:0]      speed_cmd_o,
    input wire logic                    clamp_active_o,
    input wire logic [N_OUTPUTS-1:0]    speed_match_out_o
);
    logic                    was_q;
    logic signed [POS_W-1:0] prev_q;
    logic signed [POS_W-1:0] hold_q;

    // mirrors the position the block should have captured when clamping began
    always_ff @(posedge clk_i) begin
        was_q  <= rst_n_i && clamp_active_o;
        prev_q <= motor_pos_i;
        if (clamp_active_o && !was_q) hold_q <= prev_q;
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    // ************************************************************
    // assertions
    // ************************************************************
    AST_WR_NOWAIT: assert property (avs_write_i |-> !avs_waitrequest_o)
        else $error("write was stalled");
    AST_RD_WAIT1: assert property ($rose(avs_read_i) |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
        else $error("read answer not one cycle late");
    AST_RD_UNMAP: assert property (avs_read_i && !avs_waitrequest_o && avs_address_i > 8'h1c
        |-> avs_response_o == 2'b10) else $error("unmapped read not flagged");
    AST_RD_MAPPED: assert property (avs_read_i && !avs_waitrequest_o && avs_address_i <= 8'h1c
        && avs_address_i[1:0] == 2'b00 |-> avs_response_o == 2'b00) else $error("mapped read flagged");
    AST_CLAMP_SPD: assert property ($rose(clamp_active_o) |-> $past(speed_ctrl_active_i))
        else $error("clamp outside speed control");
    AST_SPD_DROP: assert property (!speed_ctrl_active_i |=> !clamp_active_o)
        else $error("clamp kept outside speed control");
    AST_CLAMP_LVL: assert property ($rose(clamp_active_o) |->
        $past(speed_ref_i) <= 16'sd10000 && $past(speed_ref_i) >= -16'sd10000)
        else $error("clamp with reference above any level");
    AST_FIRST_ZERO: assert property ($rose(clamp_active_o) |-> speed_cmd_o == 16'sh0000)
        else $error("first clamped command not zero");
    AST_HOLD_PULL: assert property (clamp_active_o && was_q && $stable(motor_pos_i)
        && $past(motor_pos_i, 2) == motor_pos_i && motor_pos_i > hold_q + 1 |-> speed_cmd_o < 0)
        else $error("no pull back toward clamp position");
    AST_FOLLOW: assert property (!clamp_active_o && !$past(clamp_active_o)
        && !$past(clamp_active_o, 2) |-> speed_cmd_o == $past(speed_ref_i))
        else $error("command not following reference");
    AST_MATCH_OFF: assert property (!speed_ctrl_active_i |=> speed_match_out_o == '0)
        else $error("match driven outside speed control");
    AST_MATCH_1HOT: assert property ($onehot0(speed_match_out_o))
        else $error("match on several terminals");

    cover property ($rose(clamp_active_o));
    cover property ($fell(clamp_active_o));
    cover property (speed_match_out_o != '0);
endmodule

bind zcsm_top zcsm_monitor #(.N_OUTPUTS(N_OUTPUTS), .POS_W(POS_W)) u_mon (
    .clk_i, .rst_n_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_waitrequest_o, .avs_response_o,
    .speed_ctrl_active_i, .speed_ref_i, .motor_pos_i, .speed_cmd_o, .clamp_active_o, .speed_match_out_o);

// *** zcsm_pkg.sv ***
// package: register map, field layouts, reset values and types for the zero clamp / speed match block
package zcsm_pkg;

    // ************************************************************
    // register byte addresses (word aligned)
    // ************************************************************
    localparam logic [7:0] ADDR_ROT_CLAMP_LEVEL = 8'h00;
    localparam logic [7:0] ADDR_LIN_CLAMP_LEVEL = 8'h04;
    localparam logic [7:0] ADDR_ROT_MATCH_WIDTH = 8'h08;
    localparam logic [7:0] ADDR_LIN_MATCH_WIDTH = 8'h0c;
    localparam logic [7:0] ADDR_CONFIG          = 8'h10;
    localparam logic [7:0] ADDR_MAX_SPEED       = 8'h14;
    localparam logic [7:0] ADDR_STATUS          = 8'h18;
    localparam logic [7:0] ADDR_CLAMP_POS       = 8'h1c;

    // ************************************************************
    // reset values and range limits
    // ************************************************************
    localparam logic [15:0] RST_CLAMP_LEVEL = 16'h000a;
    localparam logic [15:0] RST_MATCH_WIDTH = 16'h000a;
    localparam logic [15:0] RST_MAX_SPEED   = 16'h1770;
    localparam logic [15:0] MAX_CLAMP_LEVEL = 16'h2710;
    localparam logic [15:0] MAX_MATCH_WIDTH = 16'h0064;
    localparam logic [31:0] RST_CONFIG      = 32'h0000_0000;

    // ************************************************************
    // config register field positions
    // ************************************************************
    localparam int CFG_METHOD_LSB   = 0;   // 4 bits control method
    localparam int CFG_ALLOC_MODE   = 4;   // input allocation mode
    localparam int CFG_LINEAR       = 5;   // linear motor units
    localparam int CFG_CLAMP_LSB    = 8;   // 4 bits clamp input allocation
    localparam int CFG_OUT_LSB      = 12;  // 2 bits match output allocation

    // clamp input allocation codes
    localparam logic [3:0] ALLOC_ALWAYS_ON  = 4'h7;
    localparam logic [3:0] ALLOC_ALWAYS_OFF = 4'h8;
    localparam logic [3:0] ALLOC_DEFAULT_IN = 4'h0;

    typedef enum logic [3:0] {
        METHOD_SPEED        = 4'h0,
        METHOD_POSITION     = 4'h1,
        METHOD_TORQUE       = 4'h2,
        METHOD_INT_SPEED    = 4'h3,
        METHOD_INT_OR_ANA   = 4'h4,
        METHOD_INT_OR_POS   = 4'h5,
        METHOD_INT_OR_TRQ   = 4'h6,
        METHOD_POS_OR_SPEED = 4'h7,
        METHOD_TRQ_OR_SPEED = 4'h9,
        METHOD_ANA_OR_CLAMP = 4'ha
    } zcsm_method_type;

    typedef enum logic [1:0] {
        ST_FOLLOW = 2'b00,
        ST_CLAMP  = 2'b01,
        ST_RELEASE = 2'b11
    } zcsm_state_type;

    typedef struct packed {
        logic [3:0] method;
        logic       alloc_mode;
        logic       linear;
        logic [3:0] clamp_alloc;
        logic [1:0] out_alloc;
    } zcsm_cfg_type;

endpackage

// *** zcsm_top.sv ***
// zero clamp and speed match logic with an avalon-mm register slave
//
// What this block does
// - clamp request plus reference at or below clamp level locks the motor
// - while clamped, own position loop runs and the speed reference is ignored
// - motor held within one feedback pulse of the clamp position, pulled back
// - no clamping ever while the clamp request is inactive
// - custom allocation mode takes request from selected input, else default input
// - clamping only for method codes 0,3,4,5,6,7,9,A and only in speed control
// - switching methods 5,6,7,9 suppress clamping outside speed control
// - allocation "always active" clamps whenever reference is at or below level
// - control method codes follow the documented encoding
// - clamp level 0 to 10000, default 10, effective immediately
// - clamp level above motor maximum speed is saturated to that maximum
// - speed match output driven only during speed control
// - speed match active when abs(reference minus speed) within width
// - match width 0 to 100, default 10, effective immediately
// - speed match routed to the output terminal chosen by its allocation
`timescale 1ns/1ps
module zcsm_top #(
    parameter int N_INPUTS  = 7,
    parameter int N_OUTPUTS = 3,
    parameter int POS_W     = 32,
    parameter int GAIN_SHIFT = 2
) (
    input  wire logic                 clk_i,
    input  wire logic                 rst_n_i,
    // avalon-mm slave
    input  wire logic [7:0]           avs_address_i,
    input  wire logic                 avs_read_i,
    input  wire logic                 avs_write_i,
    input  wire logic [31:0]          avs_writedata_i,
    input  wire logic [3:0]           avs_byteenable_i,
    output logic [31:0]               avs_readdata_o,
    output logic                      avs_waitrequest_o,
    output logic [1:0]                avs_response_o,
    // drive-side signals
    input  wire logic [N_INPUTS-1:0]  seq_in_i,
    input  wire logic                 speed_ctrl_active_i,
    input  wire logic signed [15:0]   speed_ref_i,
    input  wire logic signed [15:0]   motor_speed_i,
    input  wire logic signed [POS_W-1:0] motor_pos_i,
    output logic signed [15:0]        speed_cmd_o,
    output logic                      clamp_active_o,
    output logic [N_OUTPUTS-1:0]      speed_match_out_o
);

    initial begin
        if (N_INPUTS < 1 || N_INPUTS > 7 || N_OUTPUTS < 1 || N_OUTPUTS > 4 || POS_W < 17 || GAIN_SHIFT > 15)
            $error("zcsm_top: unsupported parameter values");
    end

    // ************************************************************
    // pin input synchroniser: three flops, change taken when 2 and 3 agree
    // ************************************************************
    logic [N_INPUTS-1:0] sync1_q, sync2_q, sync3_q, seq_q, seq_d;

    genvar gi;
    generate
        for (gi = 0; gi < N_INPUTS; gi++) begin : g_in
            assign seq_d[gi] = (sync2_q[gi] == sync3_q[gi]) ? sync3_q[gi] : seq_q[gi];
        end
    endgenerate

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            sync1_q <= '0;
            sync2_q <= '0;
            sync3_q <= '0;
            seq_q   <= '0;
        end else begin
            sync1_q <= seq_in_i;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            seq_q   <= seq_d;
        end
    end

    // ************************************************************
    // registers
    // ************************************************************
    logic [15:0] rot_clamp_level_q, lin_clamp_level_q;
    logic [15:0] rot_match_width_q, lin_match_width_q;
    logic [15:0] max_speed_q;
    logic [31:0] config_q;
    logic        rd_done_q;
    logic [31:0] rdata_q;
    logic [1:0]  resp_q;

    function automatic logic [15:0] be_merge(input logic [15:0] old, input logic [31:0] wd,
                                             input logic [3:0] be, input logic [15:0] lim);
        logic [15:0] v;
        v = old;
        if (be[0]) v[7:0] = wd[7:0];
        if (be[1]) v[15:8] = wd[15:8];
        be_merge = (v > lim) ? lim : v;
    endfunction

    wire wr_rot_cl = avs_write_i && avs_address_i == zcsm_pkg::ADDR_ROT_CLAMP_LEVEL;
    wire wr_lin_cl = avs_write_i && avs_address_i == zcsm_pkg::ADDR_LIN_CLAMP_LEVEL;
    wire wr_rot_mw = avs_write_i && avs_address_i == zcsm_pkg::ADDR_ROT_MATCH_WIDTH;
    wire wr_lin_mw = avs_write_i && avs_address_i == zcsm_pkg::ADDR_LIN_MATCH_WIDTH;
    wire wr_cfg    = avs_write_i && avs_address_i == zcsm_pkg::ADDR_CONFIG;
    wire wr_max    = avs_write_i && avs_address_i == zcsm_pkg::ADDR_MAX_SPEED;

    // writes finish in one cycle; reads take one registered cycle
    assign avs_waitrequest_o = avs_read_i && !rd_done_q;
    assign avs_readdata_o    = rdata_q;
    assign avs_response_o    = resp_q;

    logic [31:0] cfg_merged;
    always_comb begin
        cfg_merged = config_q;
        for (int b = 0; b < 2; b++) begin
            if (avs_byteenable_i[b]) cfg_merged[8*b +: 8] = avs_writedata_i[8*b +: 8];
        end
        cfg_merged[31:14] = '0;
        cfg_merged[7:6]   = '0;
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rot_clamp_level_q <= zcsm_pkg::RST_CLAMP_LEVEL;
            lin_clamp_level_q <= zcsm_pkg::RST_CLAMP_LEVEL;
            rot_match_width_q <= zcsm_pkg::RST_MATCH_WIDTH;
            lin_match_width_q <= zcsm_pkg::RST_MATCH_WIDTH;
            max_speed_q       <= zcsm_pkg::RST_MAX_SPEED;
            config_q          <= zcsm_pkg::RST_CONFIG;
        end else begin
            // values above range saturate at the top of range
            if (wr_rot_cl) rot_clamp_level_q <= be_merge(rot_clamp_level_q, avs_writedata_i,
                                                         avs_byteenable_i, zcsm_pkg::MAX_CLAMP_LEVEL);
            if (wr_lin_cl) lin_clamp_level_q <= be_merge(lin_clamp_level_q, avs_writedata_i,
                                                         avs_byteenable_i, zcsm_pkg::MAX_CLAMP_LEVEL);
            if (wr_rot_mw) rot_match_width_q <= be_merge(rot_match_width_q, avs_writedata_i,
                                                         avs_byteenable_i, zcsm_pkg::MAX_MATCH_WIDTH);
            if (wr_lin_mw) lin_match_width_q <= be_merge(lin_match_width_q, avs_writedata_i,
                                                         avs_byteenable_i, zcsm_pkg::MAX_MATCH_WIDTH);
            if (wr_max)    max_speed_q <= be_merge(max_speed_q, avs_writedata_i,
                                                   avs_byteenable_i, 16'h7fff);
            if (wr_cfg)    config_q <= cfg_merged;
        end
    end

    // ************************************************************
    // configuration decode
    // ************************************************************
    zcsm_pkg::zcsm_cfg_type cfg;
    assign cfg.method      = config_q[zcsm_pkg::CFG_METHOD_LSB +: 4];
    assign cfg.alloc_mode  = config_q[zcsm_pkg::CFG_ALLOC_MODE];
    assign cfg.linear      = config_q[zcsm_pkg::CFG_LINEAR];
    assign cfg.clamp_alloc = config_q[zcsm_pkg::CFG_CLAMP_LSB +: 4];
    assign cfg.out_alloc   = config_q[zcsm_pkg::CFG_OUT_LSB +: 2];

    function automatic logic method_allows_clamp(input logic [3:0] m);
        case (m)
            zcsm_pkg::METHOD_SPEED, zcsm_pkg::METHOD_INT_SPEED, zcsm_pkg::METHOD_INT_OR_ANA,
            zcsm_pkg::METHOD_INT_OR_POS, zcsm_pkg::METHOD_INT_OR_TRQ, zcsm_pkg::METHOD_POS_OR_SPEED,
            zcsm_pkg::METHOD_TRQ_OR_SPEED, zcsm_pkg::METHOD_ANA_OR_CLAMP: method_allows_clamp = 1'b1;
            default: method_allows_clamp = 1'b0;
        endcase
    endfunction

    function automatic logic [15:0] abs16(input logic signed [15:0] v);
        abs16 = v[15] ? 16'(-v) : 16'(v);
    endfunction

    // speed-control status gates both functions; switching methods lose
    // clamping whenever the selected control is not speed
    wire method_ok   = method_allows_clamp(cfg.method) && speed_ctrl_active_i;

    // request source selection
    wire [3:0] in_sel = cfg.alloc_mode ? cfg.clamp_alloc : zcsm_pkg::ALLOC_DEFAULT_IN;
    wire req_from_pin = (in_sel < 4'(N_INPUTS)) ? seq_q[in_sel[2:0]] : 1'b0;
    wire clamp_req    = (cfg.alloc_mode && cfg.clamp_alloc == zcsm_pkg::ALLOC_ALWAYS_ON) ? 1'b1
                      : req_from_pin;

    // effective clamp level, saturated at motor maximum speed
    wire [15:0] level_raw = cfg.linear ? lin_clamp_level_q : rot_clamp_level_q;
    wire [15:0] level_eff = (level_raw > max_speed_q) ? max_speed_q : level_raw;
    wire        ref_low   = abs16(speed_ref_i) <= level_eff;
    wire        clamp_go  = clamp_req && ref_low && method_ok;

    // ************************************************************
    // clamp state machine and position loop
    // ************************************************************
    zcsm_pkg::zcsm_state_type state_q, state_d;
    logic signed [POS_W-1:0] hold_pos_q;
    logic signed [15:0]      cmd_q, cmd_d;

    always_comb begin
        case (state_q)
            zcsm_pkg::ST_FOLLOW:  state_d = clamp_go ? zcsm_pkg::ST_CLAMP : zcsm_pkg::ST_FOLLOW;
            zcsm_pkg::ST_CLAMP:   state_d = clamp_go ? zcsm_pkg::ST_CLAMP : zcsm_pkg::ST_RELEASE;
            zcsm_pkg::ST_RELEASE: state_d = zcsm_pkg::ST_FOLLOW;
            default:              state_d = zcsm_pkg::ST_FOLLOW;
        endcase
    end

    // position error: a one-pulse dead band keeps the motor within one pulse
    wire signed [POS_W-1:0] pos_err = hold_pos_q - motor_pos_i;
    wire signed [POS_W-1:0] loop_out = pos_err >>> GAIN_SHIFT;
    wire                    in_band  = (pos_err >= -1) && (pos_err <= 1);
    wire signed [POS_W-1:0] pos_cmd_lim = in_band ? '0
                                        : (loop_out == '0) ? (pos_err[POS_W-1] ? -1 : 1)
                                        : loop_out;
    logic signed [15:0] pos_cmd;
    assign pos_cmd = (pos_cmd_lim > 32767) ? 16'sh7fff
                   : (pos_cmd_lim < -32767) ? -16'sh7fff
                   : 16'(pos_cmd_lim);

    always_comb begin
        // clamped: reference ignored, own loop drives otherwise follow reference
        cmd_d = (state_d == zcsm_pkg::ST_CLAMP && state_q == zcsm_pkg::ST_CLAMP) ? pos_cmd
              : (state_d == zcsm_pkg::ST_CLAMP) ? 16'sh0000
              : speed_ref_i;
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state_q    <= zcsm_pkg::ST_FOLLOW;
            hold_pos_q <= '0;
            cmd_q      <= '0;
        end else begin
            state_q <= state_d;
            cmd_q   <= cmd_d;
            // capture on entry only; release keeps the target and each new entry recaptures it, so no error carries over
            if (state_q != zcsm_pkg::ST_CLAMP && state_d == zcsm_pkg::ST_CLAMP)
                hold_pos_q <= motor_pos_i;
        end
    end

    assign speed_cmd_o    = cmd_q;
    assign clamp_active_o = (state_q == zcsm_pkg::ST_CLAMP);

    // ************************************************************
    // speed match detection and output routing
    // ************************************************************
    wire [15:0] match_width = cfg.linear ? lin_match_width_q : rot_match_width_q;
    wire signed [16:0] sdiff = 17'(speed_ref_i) - 17'(motor_speed_i);
    wire [16:0] adiff = sdiff[16] ? 17'(-sdiff) : 17'(sdiff);
    wire match_now = speed_ctrl_active_i && (adiff <= {1'b0, match_width});
    logic [N_OUTPUTS-1:0] match_q, match_d;

    generate
        for (gi = 0; gi < N_OUTPUTS; gi++) begin : g_out
            assign match_d[gi] = match_now && (cfg.out_alloc == 2'(gi));
        end
    endgenerate

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) match_q <= '0;
        else          match_q <= match_d;
    end
    assign speed_match_out_o = match_q;

    // ************************************************************
    // register readback
    // ************************************************************
    logic [31:0] rd_mux;
    logic        rd_hit;
    always_comb begin
        rd_hit = 1'b1;
        case (avs_address_i)
            zcsm_pkg::ADDR_ROT_CLAMP_LEVEL: rd_mux = {16'h0000, rot_clamp_level_q};
            zcsm_pkg::ADDR_LIN_CLAMP_LEVEL: rd_mux = {16'h0000, lin_clamp_level_q};
            zcsm_pkg::ADDR_ROT_MATCH_WIDTH: rd_mux = {16'h0000, rot_match_width_q};
            zcsm_pkg::ADDR_LIN_MATCH_WIDTH: rd_mux = {16'h0000, lin_match_width_q};
            zcsm_pkg::ADDR_CONFIG:          rd_mux = config_q;
            zcsm_pkg::ADDR_MAX_SPEED:       rd_mux = {16'h0000, max_speed_q};
            zcsm_pkg::ADDR_STATUS:          rd_mux = {16'h0000, level_eff[7:0], 3'h0, match_now,
                                                      clamp_req, ref_low, method_ok, clamp_active_o};
            zcsm_pkg::ADDR_CLAMP_POS:       rd_mux = 32'(hold_pos_q);
            default: begin
                rd_mux = 32'h0000_0000;
                rd_hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rd_done_q <= 1'b0;
            rdata_q   <= '0;
            resp_q    <= 2'b00;
        end else begin
            rd_done_q <= avs_read_i && !rd_done_q;
            if (avs_read_i && !rd_done_q) begin
                rdata_q <= rd_mux;
                resp_q  <= rd_hit ? 2'b00 : 2'b10;
            end
        end
    end

endmodule

// *** zcsm_top_tb.sv ***
// testbench: self-checking bench for the zero clamp / speed match block
`timescale 1ns/1ps
module zcsm_top_tb;
    logic               clk_i   = 1'b0;
    logic               rst_n_i = 1'b0;
    logic [7:0]         addr    = 8'h00;
    logic               rd      = 1'b0;
    logic               wr      = 1'b0;
    logic [31:0]        wdata   = 32'h0;
    logic [6:0]         pins    = 7'h00;
    logic               spd     = 1'b1;
    logic signed [15:0] ref_s   = 16'sh0000;
    logic signed [15:0] mspd    = 16'sh0000;
    logic signed [31:0] kick    = 32'sh0;
    logic [31:0]        rdata, rv;
    logic [1:0]         resp, rr;
    logic               wait_o, clamp;
    logic signed [15:0] cmd;
    logic signed [31:0] pos;
    logic [2:0]         match;
    int                 err_total = 0;
    int                 checks = 0;
    int                 cyc = 0;

    initial forever #2.5 clk_i = ~clk_i;

    zcsm_top dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
        .avs_writedata_i(wdata), .avs_byteenable_i(4'hf), .avs_readdata_o(rdata), .avs_waitrequest_o(wait_o),
        .avs_response_o(resp), .seq_in_i(pins), .speed_ctrl_active_i(spd), .speed_ref_i(ref_s),
        .motor_speed_i(mspd), .motor_pos_i(pos), .speed_cmd_o(cmd), .clamp_active_o(clamp),
        .speed_match_out_o(match));
    zcsm_host_model host (.clk_i(clk_i), .rst_n_i(rst_n_i), .speed_cmd_i(cmd), .kick_i(kick), .motor_pos_o(pos));

    // ************************************************************
    // shared tasks
    // ************************************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // holds the request until waitrequest is seen low, releases it at once, then waits one more edge
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        addr  <= a;
        wdata <= d;
        rd    <= !w;
        wr    <= w;
        @(posedge clk_i);
        while (wait_o !== 1'b0) @(posedge clk_i);
        rv = rdata;
        rr = resp;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic cfg(input logic [3:0] m, input logic mode, input logic [3:0] al, input logic [1:0] oa);
        bus(zcsm_pkg::ADDR_CONFIG, 1'b1, {18'h0, oa, al, 3'b000, mode, m});
    endtask
    // allows for the three-flop input synchroniser before judging the clamp
    task automatic cl(input logic exp);
        repeat (8) @(posedge clk_i);
        chk({31'h0, clamp}, {31'h0, exp});
    endtask

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_regs;
        for (int i = 0; i < 6; i++) begin
            bus(8'(i * 4), 1'b0, 32'h0);
            chk(rv, i == 4 ? 32'h0 : (i == 5 ? 32'h1770 : 32'h000a));
        end
        bus(8'h20, 1'b0, 32'h0);
        chk({30'h0, rr}, 32'h2);
        bus(zcsm_pkg::ADDR_ROT_CLAMP_LEVEL, 1'b1, 32'h4e20);
        bus(zcsm_pkg::ADDR_ROT_CLAMP_LEVEL, 1'b0, 32'h0);
        chk(rv, 32'h2710);
        bus(zcsm_pkg::ADDR_ROT_MATCH_WIDTH, 1'b1, 32'h00c8);
        bus(zcsm_pkg::ADDR_ROT_MATCH_WIDTH, 1'b0, 32'h0);
        chk(rv, 32'h0064);
        bus(zcsm_pkg::ADDR_ROT_CLAMP_LEVEL, 1'b1, 32'h000a);
        $display("registers done");
    endtask
    task automatic t_match;
        logic signed [15:0] sp [4] = '{16'sd1900, 16'sd2100, 16'sd1899, 16'sd2101};
        cfg(4'h0, 1'b0, 4'h0, 2'h0);
        ref_s <= 16'sd2000;
        for (int i = 0; i < 4; i++) begin
            mspd <= sp[i];
            repeat (3) @(posedge clk_i);
            chk({29'h0, match}, {31'h0, i < 2});
        end
        cfg(4'h0, 1'b0, 4'h0, 2'h2);
        mspd <= 16'sd2000;
        repeat (3) @(posedge clk_i);
        chk({29'h0, match}, 32'h4);
        spd <= 1'b0;
        repeat (3) @(posedge clk_i);
        chk({29'h0, match}, 32'h0);
        spd   <= 1'b1;
        ref_s <= 16'sh0000;
        $display("speed match done");
    endtask
    task automatic t_clamp;
        logic signed [15:0] rf [5] = '{16'sd5, 16'sd11, 16'sd10, -16'sd10, 16'sd5};
        logic [4:0]         ex     = 5'b01101;
        for (int i = 0; i < 5; i++) begin
            pins  <= {6'h0, i != 4};
            ref_s <= rf[i];
            cl(ex[i]);
        end
        $display("clamp level done");
    endtask
    task automatic t_method;
        logic [10:0] ok = 11'b11011111001;
        pins  <= 7'h01;
        ref_s <= 16'sh0000;
        for (int m = 0; m < 11; m++) begin
            cfg(4'(m), 1'b0, 4'h0, 2'h0);
            cl(ok[m]);
        end
        cfg(4'h7, 1'b0, 4'h0, 2'h0);
        spd <= 1'b0;
        cl(1'b0);
        spd <= 1'b1;
        $display("control methods done");
    endtask
    task automatic t_alloc;
        cfg(4'h0, 1'b1, 4'h3, 2'h0);
        cl(1'b0);
        pins <= 7'h08;
        cl(1'b1);
        pins <= 7'h00;
        cfg(4'h0, 1'b1, 4'h7, 2'h0);
        cl(1'b1);
        ref_s <= 16'sd11;
        cl(1'b0);
        bus(zcsm_pkg::ADDR_MAX_SPEED, 1'b1, 32'h0005);
        bus(zcsm_pkg::ADDR_ROT_CLAMP_LEVEL, 1'b1, 32'h0064);
        ref_s <= 16'sd8;
        cl(1'b0);
        ref_s <= 16'sd5;
        cl(1'b1);
        bus(zcsm_pkg::ADDR_MAX_SPEED, 1'b1, 32'h1770);
        bus(zcsm_pkg::ADDR_ROT_CLAMP_LEVEL, 1'b1, 32'h000a);
        // linear units pick the linear level: 15 clamps only against 20
        bus(zcsm_pkg::ADDR_LIN_CLAMP_LEVEL, 1'b1, 32'h0014);
        bus(zcsm_pkg::ADDR_CONFIG, 1'b1, 32'h0000_0730);
        ref_s <= 16'sd15;
        cl(1'b1);
        ref_s <= 16'sh0000;
        $display("allocation done");
    endtask
    task automatic t_hold;
        logic signed [31:0] p0, d;
        cfg(4'h0, 1'b1, 4'h8, 2'h0);
        repeat (8) @(posedge clk_i);
        p0 = pos;
        cfg(4'h0, 1'b1, 4'h7, 2'h0);
        cl(1'b1);
        bus(zcsm_pkg::ADDR_CLAMP_POS, 1'b0, 32'h0);
        chk(rv, p0);
        kick <= 32'sd20;
        @(posedge clk_i);
        kick <= 32'sh0;
        repeat (400) @(posedge clk_i);
        d = pos - p0;
        chk({31'h0, d <= 1 && d >= -1}, 32'h1);
        ref_s <= -16'sd7;
        repeat (4) @(posedge clk_i);
        chk({16'h0, cmd}, 32'h0);
        ref_s <= 16'sd500;
        repeat (6) @(posedge clk_i);
        chk({16'h0, cmd}, 32'h01f4);
        $display("position hold done");
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            close_out();
        end
    end

    initial begin
        repeat (2) @(posedge clk_i);
        rst_n_i <= 1'b1;
        t_regs();
        t_match();
        t_clamp();
        t_method();
        t_alloc();
        t_hold();
        close_out();
    end
endmodule
